// ---- common/alt_map.svh ----
// Register map, reset values, field positions and alignment constants of the alarm limit bank
`ifndef ALT_MAP_SVH
`define ALT_MAP_SVH

`define ALT_ADDR_W            6
`define ALT_DATA_W            16

`define ALT_OFS_SHUNT_UPPER   6'h0C
`define ALT_OFS_SHUNT_LOWER   6'h0D
`define ALT_OFS_BUS_UPPER     6'h0E
`define ALT_OFS_BUS_LOWER     6'h0F
`define ALT_OFS_TEMP_UPPER    6'h10
`define ALT_OFS_POWER_UPPER   6'h11
`define ALT_OFS_MAKER_ID      6'h3E
`define ALT_OFS_PART_ID       6'h3F

`define ALT_RST_SHUNT_UPPER   16'h7FFF
`define ALT_RST_SHUNT_LOWER   16'h8000
`define ALT_RST_BUS_UPPER     15'h7FFF
`define ALT_RST_BUS_LOWER     15'h0000
`define ALT_RST_TEMP_UPPER    16'h07FF
`define ALT_RST_POWER_UPPER   16'hFFFF
`define ALT_RD_ZERO           16'h0000

`define ALT_BUS_FIELD_MSB     14
`define ALT_BUS_FIELD_W       15
`define ALT_PART_DIE_MSB      15
`define ALT_PART_DIE_LSB      4
`define ALT_PART_REV_MSB      3
`define ALT_PART_REV_LSB      0

`define ALT_SHUNT_RES_W       20
`define ALT_BUS_RES_W         20
`define ALT_TEMP_RES_W        16
`define ALT_POWER_RES_W       24
`define ALT_SHUNT_ALIGN_W     4
`define ALT_BUS_ALIGN_W       4
`define ALT_POWER_ALIGN_W     8
`define ALT_SHUNT_ALIGN_PAD   4'h0
`define ALT_BUS_ALIGN_PAD     4'h0
`define ALT_BUS_RES_TOP       1'b0
`define ALT_POWER_ALIGN_PAD   8'h00

`endif

// ---- common/alt_pkg.sv ----
// Types shared by the alarm limit bank modules
package alt_pkg;

	typedef struct packed {
		logic [19:0] shunt;
		logic [19:0] bus;
		logic [15:0] temp;
		logic [23:0] power;
	} alt_meas_t;

	typedef struct packed {
		logic shunt_over;
		logic shunt_under;
		logic bus_over;
		logic bus_under;
		logic temp_over;
		logic power_over;
	} alt_flags_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [5:0]  addr;
		logic [15:0] wdata;
	} alt_reg_req_t;

	typedef enum logic [1:0] {
		ALT_ST_RUN   = 2'b01,
		ALT_ST_BLANK = 2'b10
	} alt_state_t;

endpackage

// ---- rtl/alt_limit_cmp.sv ----
// One limit comparator: strict over or under test, signed or unsigned
`timescale 1ns/1ps
module alt_limit_cmp #(
	parameter int W        = 16,
	parameter bit IS_SIGNED = 1'b1,
	parameter bit IS_OVER   = 1'b1
) (
	input  wire logic [W-1:0] meas_i,
	input  wire logic [W-1:0] limit_i,
	output logic              hit_o
);
	wire gt_w;
	wire lt_w;

	generate
		if (IS_SIGNED) begin : g_signed
			assign gt_w = $signed(meas_i) > $signed(limit_i);
			assign lt_w = $signed(meas_i) < $signed(limit_i);
		end else begin : g_unsigned
			assign gt_w = meas_i > limit_i;
			assign lt_w = meas_i < limit_i;
		end
	endgenerate

	assign hit_o = IS_OVER ? gt_w : lt_w;
endmodule

// ---- rtl/alt_avg_sel.sv ----
// Picks raw or averaged results for limit checking and holds the chosen sample
`timescale 1ns/1ps
`include "alt_map.svh"
module alt_avg_sel (
	input  wire logic             core_clk_i,
	input  wire logic             arst_n_i,
	input  wire logic             averaged_alert_option_i,
	input  wire logic             raw_valid_i,
	input  wire alt_pkg::alt_meas_t raw_meas_i,
	input  wire logic             avg_valid_i,
	input  wire alt_pkg::alt_meas_t avg_meas_i,
	output alt_pkg::alt_meas_t    sel_meas_o,
	output logic                  sel_valid_o
);
	alt_pkg::alt_meas_t sel_meas_reg;
	logic               sel_valid_reg;
	wire                take_w;
	alt_pkg::alt_meas_t src_w;

	// Averaged mode waits for the finished average, so alarms lag by the averaging window
	assign take_w = averaged_alert_option_i ? avg_valid_i : raw_valid_i;
	assign src_w  = averaged_alert_option_i ? avg_meas_i : raw_meas_i;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_meas_reg  <= '0;
			sel_valid_reg <= 1'b0;
		end else begin
			sel_valid_reg <= take_w;
			if (take_w) begin
				sel_meas_reg <= src_w;
			end
		end
	end

	assign sel_meas_o  = sel_meas_reg;
	assign sel_valid_o = sel_valid_reg;
endmodule

// ---- rtl/alt_limit_bank.sv ----
// Alarm limit register bank with identity words and limit comparators
`timescale 1ns/1ps
`include "alt_map.svh"
module alt_limit_bank #(
	parameter logic [15:0] MAKER_CODE     = 16'h4142,
	parameter logic [11:0] DIE_IDENTIFIER = 12'hA5C,
	parameter logic [3:0]  SILICON_REV    = 4'h3
) (
	input  wire logic               core_clk_i,
	input  wire logic               arst_n_i,
	input  wire alt_pkg::alt_reg_req_t reg_req_i,
	output logic [15:0]             reg_rdata_o,
	output logic                    reg_rvalid_o,
	input  wire logic               range_select_i,
	input  wire logic               averaged_alert_option_i,
	input  wire logic               raw_valid_i,
	input  wire alt_pkg::alt_meas_t raw_meas_i,
	input  wire logic               avg_valid_i,
	input  wire alt_pkg::alt_meas_t avg_meas_i,
	output alt_pkg::alt_flags_t     limit_flags_o,
	output logic                    flags_valid_o
);
	// Limit storage
	logic [15:0]                 shunt_upper_limit_reg;
	logic [15:0]                 shunt_lower_limit_reg;
	logic [`ALT_BUS_FIELD_W-1:0] bus_upper_limit_reg;
	logic [`ALT_BUS_FIELD_W-1:0] bus_lower_limit_reg;
	logic [15:0]                 temperature_limit_field_reg;
	logic [15:0]                 power_limit_field_reg;

	// Read port and comparison outputs
	logic [15:0]         rdata_reg;
	logic [15:0]         rdata_next;
	logic                rvalid_reg;
	alt_pkg::alt_flags_t flags_reg;
	logic                flags_valid_reg;
	logic                range_seen_reg;
	alt_pkg::alt_state_t state_reg;
	alt_pkg::alt_state_t state_next;

	// Address decode
	wire sel_shunt_upper_w;
	wire sel_shunt_lower_w;
	wire sel_bus_upper_w;
	wire sel_bus_lower_w;
	wire sel_temp_upper_w;
	wire sel_power_upper_w;
	wire sel_maker_w;
	wire sel_part_w;

	assign sel_shunt_upper_w = reg_req_i.addr == `ALT_OFS_SHUNT_UPPER;
	assign sel_shunt_lower_w = reg_req_i.addr == `ALT_OFS_SHUNT_LOWER;
	assign sel_bus_upper_w   = reg_req_i.addr == `ALT_OFS_BUS_UPPER;
	assign sel_bus_lower_w   = reg_req_i.addr == `ALT_OFS_BUS_LOWER;
	assign sel_temp_upper_w  = reg_req_i.addr == `ALT_OFS_TEMP_UPPER;
	assign sel_power_upper_w = reg_req_i.addr == `ALT_OFS_POWER_UPPER;
	assign sel_maker_w       = reg_req_i.addr == `ALT_OFS_MAKER_ID;
	assign sel_part_w        = reg_req_i.addr == `ALT_OFS_PART_ID;

	wire wr_shunt_upper_w;
	wire wr_shunt_lower_w;
	wire wr_bus_upper_w;
	wire wr_bus_lower_w;
	wire wr_temp_upper_w;
	wire wr_power_upper_w;

	// Identity words have no write strobe at all, so writes to them simply vanish
	assign wr_shunt_upper_w = reg_req_i.wr && sel_shunt_upper_w;
	assign wr_shunt_lower_w = reg_req_i.wr && sel_shunt_lower_w;
	assign wr_bus_upper_w   = reg_req_i.wr && sel_bus_upper_w;
	assign wr_bus_lower_w   = reg_req_i.wr && sel_bus_lower_w;
	assign wr_temp_upper_w  = reg_req_i.wr && sel_temp_upper_w;
	assign wr_power_upper_w = reg_req_i.wr && sel_power_upper_w;

	// Identity words
	wire [15:0] maker_identity_word_w;
	wire [15:0] part_identity_word_w;

	assign maker_identity_word_w = MAKER_CODE;
	assign part_identity_word_w[`ALT_PART_DIE_MSB:`ALT_PART_DIE_LSB] = DIE_IDENTIFIER;
	assign part_identity_word_w[`ALT_PART_REV_MSB:`ALT_PART_REV_LSB] = SILICON_REV;

	// Bus limit words: top bit reserved and reads zero
	wire [15:0] bus_upper_word_w;
	wire [15:0] bus_lower_word_w;

	assign bus_upper_word_w = {1'b0, bus_upper_limit_reg};
	assign bus_lower_word_w = {1'b0, bus_lower_limit_reg};

	// Read data selection, unmapped addresses read zero
	always_comb begin
		rdata_next = `ALT_RD_ZERO;
		if (sel_shunt_upper_w) begin
			rdata_next = shunt_upper_limit_reg;
		end
		if (sel_shunt_lower_w) begin
			rdata_next = shunt_lower_limit_reg;
		end
		if (sel_bus_upper_w) begin
			rdata_next = bus_upper_word_w;
		end
		if (sel_bus_lower_w) begin
			rdata_next = bus_lower_word_w;
		end
		if (sel_temp_upper_w) begin
			rdata_next = temperature_limit_field_reg;
		end
		if (sel_power_upper_w) begin
			rdata_next = power_limit_field_reg;
		end
		if (sel_maker_w) begin
			rdata_next = maker_identity_word_w;
		end
		if (sel_part_w) begin
			rdata_next = part_identity_word_w;
		end
	end

	// Limit registers
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			shunt_upper_limit_reg <= `ALT_RST_SHUNT_UPPER;
			shunt_lower_limit_reg <= `ALT_RST_SHUNT_LOWER;
			bus_upper_limit_reg   <= `ALT_RST_BUS_UPPER;
			bus_lower_limit_reg   <= `ALT_RST_BUS_LOWER;
		end else begin
			if (wr_shunt_upper_w) begin
				shunt_upper_limit_reg <= reg_req_i.wdata;
			end
			if (wr_shunt_lower_w) begin
				shunt_lower_limit_reg <= reg_req_i.wdata;
			end
			if (wr_bus_upper_w) begin
				bus_upper_limit_reg <= reg_req_i.wdata[`ALT_BUS_FIELD_MSB:0];
			end
			if (wr_bus_lower_w) begin
				bus_lower_limit_reg <= reg_req_i.wdata[`ALT_BUS_FIELD_MSB:0];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			temperature_limit_field_reg <= `ALT_RST_TEMP_UPPER;
			power_limit_field_reg       <= `ALT_RST_POWER_UPPER;
		end else begin
			if (wr_temp_upper_w) begin
				temperature_limit_field_reg <= reg_req_i.wdata;
			end
			if (wr_power_upper_w) begin
				power_limit_field_reg <= reg_req_i.wdata;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_reg  <= `ALT_RD_ZERO;
			rvalid_reg <= 1'b0;
		end else begin
			rvalid_reg <= reg_req_i.rd;
			if (reg_req_i.rd) begin
				rdata_reg <= rdata_next;
			end
		end
	end

	// Sample chosen for comparison
	alt_pkg::alt_meas_t sel_meas_w;
	wire                sel_valid_w;

	alt_avg_sel u_avg_sel (
		.core_clk_i              (core_clk_i),
		.arst_n_i                (arst_n_i),
		.averaged_alert_option_i (averaged_alert_option_i),
		.raw_valid_i             (raw_valid_i),
		.raw_meas_i              (raw_meas_i),
		.avg_valid_i             (avg_valid_i),
		.avg_meas_i              (avg_meas_i),
		.sel_meas_o              (sel_meas_w),
		.sel_valid_o             (sel_valid_w)
	);

	// Limits aligned to the result LSB. Shunt steps are 16 result LSBs in either range,
	// so the alignment does not depend on the range select.
	wire [`ALT_SHUNT_RES_W-1:0] shunt_upper_al_w;
	wire [`ALT_SHUNT_RES_W-1:0] shunt_lower_al_w;
	wire [`ALT_BUS_RES_W-1:0]   bus_upper_al_w;
	wire [`ALT_BUS_RES_W-1:0]   bus_lower_al_w;
	wire [`ALT_POWER_RES_W-1:0] power_upper_al_w;

	assign shunt_upper_al_w = {shunt_upper_limit_reg, `ALT_SHUNT_ALIGN_PAD};
	assign shunt_lower_al_w = {shunt_lower_limit_reg, `ALT_SHUNT_ALIGN_PAD};
	// Bus limit step is 16 result LSBs: one zero on top, four below the 15-bit field
	assign bus_upper_al_w   = {`ALT_BUS_RES_TOP, bus_upper_limit_reg, `ALT_BUS_ALIGN_PAD};
	assign bus_lower_al_w   = {`ALT_BUS_RES_TOP, bus_lower_limit_reg, `ALT_BUS_ALIGN_PAD};
	assign power_upper_al_w = {power_limit_field_reg, `ALT_POWER_ALIGN_PAD};

	alt_pkg::alt_flags_t hit_w;

	alt_limit_cmp #(.W(`ALT_SHUNT_RES_W), .IS_SIGNED(1'b1), .IS_OVER(1'b1)) u_cmp_shunt_over (
		.meas_i  (sel_meas_w.shunt),
		.limit_i (shunt_upper_al_w),
		.hit_o   (hit_w.shunt_over)
	);

	alt_limit_cmp #(.W(`ALT_SHUNT_RES_W), .IS_SIGNED(1'b1), .IS_OVER(1'b0)) u_cmp_shunt_under (
		.meas_i  (sel_meas_w.shunt),
		.limit_i (shunt_lower_al_w),
		.hit_o   (hit_w.shunt_under)
	);

	alt_limit_cmp #(.W(`ALT_BUS_RES_W), .IS_SIGNED(1'b0), .IS_OVER(1'b1)) u_cmp_bus_over (
		.meas_i  (sel_meas_w.bus),
		.limit_i (bus_upper_al_w),
		.hit_o   (hit_w.bus_over)
	);

	alt_limit_cmp #(.W(`ALT_BUS_RES_W), .IS_SIGNED(1'b0), .IS_OVER(1'b0)) u_cmp_bus_under (
		.meas_i  (sel_meas_w.bus),
		.limit_i (bus_lower_al_w),
		.hit_o   (hit_w.bus_under)
	);

	alt_limit_cmp #(.W(`ALT_TEMP_RES_W), .IS_SIGNED(1'b1), .IS_OVER(1'b1)) u_cmp_temp_over (
		.meas_i  (sel_meas_w.temp),
		.limit_i (temperature_limit_field_reg),
		.hit_o   (hit_w.temp_over)
	);

	alt_limit_cmp #(.W(`ALT_POWER_RES_W), .IS_SIGNED(1'b0), .IS_OVER(1'b1)) u_cmp_power_over (
		.meas_i  (sel_meas_w.power),
		.limit_i (power_upper_al_w),
		.hit_o   (hit_w.power_over)
	);

	// A range change leaves one sample taken at the old scale in flight; it is not judged
	wire range_changed_w;

	assign range_changed_w = range_select_i != range_seen_reg;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			alt_pkg::ALT_ST_RUN: begin
				if (range_changed_w) begin
					state_next = alt_pkg::ALT_ST_BLANK;
				end
			end
			alt_pkg::ALT_ST_BLANK: begin
				if (sel_valid_w && !range_changed_w) begin
					state_next = alt_pkg::ALT_ST_RUN;
				end
			end
			default: begin
				state_next = alt_pkg::ALT_ST_RUN;
			end
		endcase
	end

	wire judge_w;

	assign judge_w = sel_valid_w && (state_reg == alt_pkg::ALT_ST_RUN) && !range_changed_w;

	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_reg      <= alt_pkg::ALT_ST_RUN;
			range_seen_reg <= 1'b0;
		end else begin
			state_reg      <= state_next;
			range_seen_reg <= range_select_i;
		end
	end

	// Flags follow each judged sample; latching and clearing live downstream
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			flags_reg       <= '0;
			flags_valid_reg <= 1'b0;
		end else begin
			flags_valid_reg <= judge_w;
			if (judge_w) begin
				flags_reg <= hit_w;
			end
		end
	end

	assign reg_rdata_o   = rdata_reg;
	assign reg_rvalid_o  = rvalid_reg;
	assign limit_flags_o = flags_reg;
	assign flags_valid_o = flags_valid_reg;
endmodule

// ---- verif/alt_limit_bank_assertions.sv ----
// Concurrent checks on the alarm limit bank ports
`timescale 1ns/1ps
`include "alt_map.svh"
module alt_limit_bank_assertions #(
	parameter logic [15:0] MAKER_CODE     = 16'h4142,
	parameter logic [11:0] DIE_IDENTIFIER = 12'hA5C,
	parameter logic [3:0]  SILICON_REV    = 4'h3
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  arst_n_i,
	input  wire alt_pkg::alt_reg_req_t reg_req_i,
	input  wire logic [15:0]           reg_rdata_o,
	input  wire logic                  reg_rvalid_o,
	input  wire logic                  range_select_i,
	input  wire logic                  averaged_alert_option_i,
	input  wire logic                  raw_valid_i,
	input  wire alt_pkg::alt_meas_t    raw_meas_i,
	input  wire logic                  avg_valid_i,
	input  wire alt_pkg::alt_meas_t    avg_meas_i,
	input  wire alt_pkg::alt_flags_t   limit_flags_o,
	input  wire logic                  flags_valid_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	// Shadow of the temperature limit, so the flag can be tied to what the host wrote
	logic [15:0] temp_lim_reg;
	wire         temp_wr = reg_req_i.wr && (reg_req_i.addr == `ALT_OFS_TEMP_UPPER);
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			temp_lim_reg <= `ALT_RST_TEMP_UPPER;
		else if (temp_wr)
			temp_lim_reg <= reg_req_i.wdata;
	end
	wire unmapped = !(reg_req_i.addr inside {[6'h0C:6'h11], 6'h3E, 6'h3F});
	a_read_answer: assert property (reg_req_i.rd |=> reg_rvalid_o) else $error("read not answered");
	a_no_stray_answer: assert property (!reg_req_i.rd |=> !reg_rvalid_o) else $error("answer without read");
	a_maker_word: assert property (reg_req_i.rd && reg_req_i.addr == `ALT_OFS_MAKER_ID |=>
		reg_rdata_o == MAKER_CODE) else $error("maker word wrong");
	a_part_word: assert property (reg_req_i.rd && reg_req_i.addr == `ALT_OFS_PART_ID |=>
		reg_rdata_o == {DIE_IDENTIFIER, SILICON_REV}) else $error("part word wrong");
	a_bus_top_zero: assert property (reg_req_i.rd && reg_req_i.addr inside {6'h0E, 6'h0F} |=>
		!reg_rdata_o[15]) else $error("bus limit bit 15 set");
	a_unmapped_zero: assert property (reg_req_i.rd && unmapped |=> reg_rdata_o == 16'h0000)
		else $error("unmapped read not zero");
	a_flag_cause: assert property (flags_valid_o |-> $past(raw_valid_i && !averaged_alert_option_i, 2) ||
		$past(avg_valid_i && averaged_alert_option_i, 2)) else $error("flag update without sample");
	a_temp_judge: assert property (flags_valid_o && !$past(averaged_alert_option_i, 2) |->
		limit_flags_o.temp_over == ($signed($past(raw_meas_i.temp, 2)) > $signed(temp_lim_reg)))
		else $error("temperature flag wrong");
	a_flags_hold: assert property (!flags_valid_o |-> $stable(limit_flags_o)) else $error("flags moved");
	c_shunt_over: cover property (flags_valid_o && limit_flags_o.shunt_over);
	c_read: cover property (reg_rvalid_o);
	c_averaged: cover property (flags_valid_o && averaged_alert_option_i);
endmodule
bind alt_limit_bank alt_limit_bank_assertions #(
	.MAKER_CODE(MAKER_CODE), .DIE_IDENTIFIER(DIE_IDENTIFIER), .SILICON_REV(SILICON_REV)
) u_chk (
	.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .range_select_i(range_select_i),
	.averaged_alert_option_i(averaged_alert_option_i), .raw_valid_i(raw_valid_i), .raw_meas_i(raw_meas_i),
	.avg_valid_i(avg_valid_i), .avg_meas_i(avg_meas_i), .limit_flags_o(limit_flags_o),
	.flags_valid_o(flags_valid_o)
);

// ---- verif/alt_host_model.sv ----
// Host model issuing register strobes to the limit bank
`timescale 1ns/1ps
module alt_host_model (
	input  wire logic             core_clk_i,
	output alt_pkg::alt_reg_req_t reg_req_o,
	input  wire logic [15:0]      reg_rdata_i,
	input  wire logic             reg_rvalid_i
);
	initial reg_req_o = '0;
	// Released address and data are inverted so a design cannot lean on stale values
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(negedge core_clk_i);
		reg_req_o = '{1'b1, 1'b0, a, d};
		@(negedge core_clk_i);
		reg_req_o = '{1'b0, 1'b0, ~a, ~d};
	endtask
	task automatic rd(input logic [5:0] a, output logic [15:0] d, output logic v);
		@(negedge core_clk_i);
		reg_req_o = '{1'b0, 1'b1, a, 16'h0000};
		@(negedge core_clk_i);
		reg_req_o = '{1'b0, 1'b0, ~a, 16'hFFFF};
		// The answer rose on the edge that took the strobe and stands until the next one
		v = reg_rvalid_i;
		d = reg_rdata_i;
	endtask
endmodule

// ---- verif/tb_top.sv ----
// Self-checking bench for the alarm limit bank
`timescale 1ns/1ps
`include "alt_map.svh"
module tb_top;
	// Identity values are arbitrary
	localparam logic [15:0] MAKER = 16'h4D4B;
	localparam logic [11:0] DIE   = 12'h3C7;
	localparam logic [3:0]  REV   = 4'h9;
	logic                  core_clk_i;
	logic                  arst_n_i;
	alt_pkg::alt_reg_req_t reg_req;
	logic [15:0]           rdata;
	logic                  rvalid;
	logic                  range_sel;
	logic                  avg_opt;
	logic                  raw_valid;
	logic                  avg_valid;
	alt_pkg::alt_meas_t    raw_meas;
	alt_pkg::alt_meas_t    avg_meas;
	alt_pkg::alt_flags_t   flags;
	logic                  flags_valid;
	int                    failures = 0;
	int                    compares = 0;
	alt_host_model u_host (.core_clk_i(core_clk_i), .reg_req_o(reg_req), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid));
	alt_limit_bank #(.MAKER_CODE(MAKER), .DIE_IDENTIFIER(DIE), .SILICON_REV(REV)) u_dut (
		.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .range_select_i(range_sel), .averaged_alert_option_i(avg_opt),
		.raw_valid_i(raw_valid), .raw_meas_i(raw_meas), .avg_valid_i(avg_valid), .avg_meas_i(avg_meas),
		.limit_flags_o(flags), .flags_valid_o(flags_valid));
	initial begin
		core_clk_i = 1'b0;
		forever #4 core_clk_i = ~core_clk_i;
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic rdchk(input logic [5:0] a, input logic [15:0] exp);
		logic [15:0] d;
		logic        v;
		u_host.rd(a, d, v);
		check("rvalid", {15'h0000, v}, 16'h0001);
		check("rdata", d, exp);
	endtask
	// One sample on the chosen stream; rs is the range level applied in the same cycle
	task automatic sample(input logic use_avg, input logic rs, input alt_pkg::alt_meas_t m, input logic judged,
		input logic [5:0] exp);
		@(negedge core_clk_i);
		range_sel = rs;
		if (use_avg) begin
			avg_valid = 1'b1;
			avg_meas = m;
		end else begin
			raw_valid = 1'b1;
			raw_meas = m;
		end
		@(negedge core_clk_i);
		raw_valid = 1'b0;
		avg_valid = 1'b0;
		raw_meas = ~m;
		avg_meas = ~m;
		// Flag pulse rose on the second edge after the sample and stands one cycle
		@(negedge core_clk_i);
		check("flags_valid", {15'h0000, flags_valid}, {15'h0000, judged});
		if (judged)
			check("flags", {10'h000, flags}, {10'h000, exp});
	endtask
	task automatic complete_run();
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		complete_run();
	end
	initial begin
		arst_n_i = 1'b0;
		range_sel = 1'b0;
		avg_opt = 1'b0;
		raw_valid = 1'b0;
		avg_valid = 1'b0;
		raw_meas = '0;
		avg_meas = '0;
		repeat (10) @(negedge core_clk_i);
		arst_n_i = 1'b1;
		rdchk(6'h0C, 16'h7FFF);
		rdchk(6'h0D, 16'h8000);
		rdchk(6'h0E, 16'h7FFF);
		rdchk(6'h0F, 16'h0000);
		rdchk(6'h10, 16'h07FF);
		rdchk(6'h11, 16'hFFFF);
		rdchk(6'h3E, MAKER);
		rdchk(6'h3F, {DIE, REV});
		rdchk(6'h20, 16'h0000);
		$display("test reset_values done");
		for (int a = 12; a < 18; a++)
			u_host.wr(a[5:0], 16'hFFFF);
		u_host.wr(6'h3E, 16'h0000);
		u_host.wr(6'h3F, 16'h0000);
		u_host.wr(6'h20, 16'hFFFF);
		rdchk(6'h0C, 16'hFFFF);
		rdchk(6'h0D, 16'hFFFF);
		rdchk(6'h0E, 16'h7FFF);
		rdchk(6'h0F, 16'h7FFF);
		rdchk(6'h10, 16'hFFFF);
		rdchk(6'h11, 16'hFFFF);
		rdchk(6'h3E, MAKER);
		rdchk(6'h3F, {DIE, REV});
		rdchk(6'h20, 16'h0000);
		$display("test access done");
		// Upper stays the larger of the two negative shunt limits
		u_host.wr(6'h0D, 16'h8001);
		u_host.wr(6'h0E, 16'h0010);
		u_host.wr(6'h0F, 16'h0010);
		u_host.wr(6'h11, 16'h0001);
		sample(1'b0, 1'b0, '{20'h00000, 20'h00101, 16'h0000, 24'h000100}, 1'b1, 6'b101010);
		sample(1'b0, 1'b0, '{20'h80000, 20'h00000, 16'h8000, 24'h000101}, 1'b1, 6'b010101);
		$display("test compare done");
		avg_opt = 1'b1;
		sample(1'b0, 1'b0, '{20'h80000, 20'h00000, 16'h8000, 24'h000101}, 1'b0, 6'b000000);
		sample(1'b1, 1'b0, '{20'h00000, 20'h00101, 16'h0000, 24'h000100}, 1'b1, 6'b101010);
		avg_opt = 1'b0;
		$display("test averaged done");
		sample(1'b0, 1'b1, '{20'h80000, 20'h00000, 16'h8000, 24'h000101}, 1'b0, 6'b000000);
		sample(1'b0, 1'b1, '{20'h80000, 20'h00000, 16'h8000, 24'h000101}, 1'b1, 6'b010101);
		sample(1'b0, 1'b1, '{20'h80000, 20'h00000, 16'h8000, 24'h000101}, 1'b1, 6'b010101);
		$display("test range done");
		@(negedge core_clk_i);
		arst_n_i = 1'b0;
		range_sel = 1'b0;
		@(negedge core_clk_i);
		arst_n_i = 1'b1;
		check("flags_after_reset", {10'h000, flags}, 16'h0000);
		rdchk(6'h0D, 16'h8000);
		rdchk(6'h0F, 16'h0000);
		$display("test second_reset done");
		complete_run();
	end
endmodule
